/* shared/dsfr_defines.svh */
`ifndef DSFR_DEFINES_SVH
`define DSFR_DEFINES_SVH
// register offsets
`define DSFR_OFF_GAIN_STATUS   7'h26
`define DSFR_OFF_RSV_LO        7'h27
`define DSFR_OFF_RSV_HI        7'h29
`define DSFR_OFF_OVF_STICKY    7'h2A
`define DSFR_OFF_OVF_LIVE      7'h2B
`define DSFR_OFF_OC_STICKY     7'h2C
`define DSFR_OFF_RSV_2D        7'h2D
`define DSFR_OFF_OC_LIVE       7'h2E
`define DSFR_OFF_RSV_2F        7'h2F
`define DSFR_OFF_INTERRUPT_PIN_ONE_CTRL     7'h30
`define DSFR_OFF_INTERRUPT_PIN_TWO_CTRL     7'h31
// field positions
`define DSFR_BIT_GAIN_MATCH    4
`define DSFR_BIT_FLAG          7
`define DSFR_BIT_OC_EN         3
`define DSFR_BIT_PULSE_MODE    0
// reset values
`define DSFR_RST_FLAG          1'b0
`define DSFR_RST_CTRL          8'h00
// timing
`define DSFR_PULSE_MS          2
`define DSFR_CLK_MHZ           100
`define DSFR_PULSE_CYCLES      (`DSFR_PULSE_MS * 1000 * `DSFR_CLK_MHZ)
`endif

/* shared/dsfr_pkg.sv */
package dsfr_pkg;
	// one register access from the control port
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} dsfr_req_t;
	// raw status conditions from the analog and dsp blocks
	typedef struct packed {
		logic gain_match;
		logic dac_overflow;
		logic hp_overcurrent;
	} dsfr_cond_t;
endpackage : dsfr_pkg

/* src/dsfr_int_pin.sv */
`timescale 1ns/1ns
`include "dsfr_defines.svh"
// one interrupt pin: single 2 ms pulse or a train of 2 ms pulses
module dsfr_int_pin #(
	parameter int PULSE_CYCLES = `DSFR_PULSE_CYCLES
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// control
	input  wire logic enable,
	input  wire logic train_mode,
	input  wire logic oc_rise,
	input  wire logic stop_train,
	// pin
	output logic      pin
);
	typedef enum logic [1:0] {DSFR_IDLE, DSFR_HIGH, DSFR_LOW} dsfr_pin_state_t;
	dsfr_pin_state_t st_r, st_nxt;
	logic [31:0] cnt_r;
	wire         cnt_done = (cnt_r == 32'(PULSE_CYCLES - 1));
	wire         start    = enable & oc_rise;

	// pulse sequencer; a read stop wins over a restart in the low phase
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			DSFR_IDLE: if (start) st_nxt = DSFR_HIGH;
			DSFR_HIGH: if (stop_train) st_nxt = DSFR_IDLE;
				else if (cnt_done) st_nxt = train_mode ? DSFR_LOW : DSFR_IDLE;
			DSFR_LOW:  if (stop_train) st_nxt = DSFR_IDLE;
				else if (cnt_done) st_nxt = DSFR_HIGH;
			// the fourth code is no state; fall back to idle rather than stick
			default:   st_nxt = DSFR_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r  <= DSFR_IDLE;
			cnt_r <= 32'h0;
			pin   <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= (st_nxt != st_r || st_r == DSFR_IDLE) ? 32'h0 : cnt_r + 32'h1;
			pin   <= (st_nxt == DSFR_HIGH);
		end
	end

	property p_pulse_len;
		@(posedge mclk) disable iff (!reset_n)
		(st_r == DSFR_HIGH && cnt_done && !stop_train && !train_mode) |=> !pin;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("single pulse did not end");

	property p_no_int_disabled;
		@(posedge mclk) disable iff (!reset_n)
		(st_r == DSFR_IDLE && !start) |=> !pin;
	endproperty
	a_no_int_disabled: assert property (p_no_int_disabled) else $error("pin rose without cause");

	property p_stop;
		@(posedge mclk) disable iff (!reset_n)
		(st_r != DSFR_IDLE && stop_train) |=> !pin;
	endproperty
	a_stop: assert property (p_stop) else $error("train did not stop on read");
endmodule : dsfr_int_pin

/* src/dsfr_flag_regs.sv */
`timescale 1ns/1ns
`include "dsfr_defines.svh"
module dsfr_flag_regs #(
	parameter int PULSE_CYCLES = `DSFR_PULSE_CYCLES
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             reset_n,
	// register access from the control port, on mclk
	input  wire dsfr_pkg::dsfr_req_t req,
	output logic [7:0]            rdata,
	// raw conditions from outside the domain
	input  wire dsfr_pkg::dsfr_cond_t cond_async,
	// interrupt pins
	output logic                  interrupt_pin_one,
	output logic                  interrupt_pin_two
);
	dsfr_pkg::dsfr_cond_t s1_r, s2_r;
	logic       ovf_sticky_r, oc_sticky_r, oc_prev_r;
	logic [7:0] interrupt_pin_one_ctrl_r, interrupt_pin_two_ctrl_r;

	// decode
	wire rd_ovf_sticky = req.rd && req.addr == `DSFR_OFF_OVF_STICKY;
	wire rd_oc_sticky  = req.rd && req.addr == `DSFR_OFF_OC_STICKY;
	wire wr_interrupt_pin_one       = req.wr && req.addr == `DSFR_OFF_INTERRUPT_PIN_ONE_CTRL;
	wire wr_interrupt_pin_two       = req.wr && req.addr == `DSFR_OFF_INTERRUPT_PIN_TWO_CTRL;
	wire oc_rise       = s2_r.hp_overcurrent & ~oc_prev_r;
	wire stop_train    = rd_ovf_sticky | rd_oc_sticky;

	// two-stage synchroniser; conditions are asynchronous to mclk
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r      <= '0;
			s2_r      <= '0;
			oc_prev_r <= 1'b0;
		end else begin
			s1_r      <= cond_async;
			s2_r      <= s1_r;
			oc_prev_r <= s2_r.hp_overcurrent;
		end
	end

	// sticky flags: set dominates the clearing read so no event is lost
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ovf_sticky_r <= `DSFR_RST_FLAG;
			oc_sticky_r  <= `DSFR_RST_FLAG;
		end else begin
			ovf_sticky_r <= s2_r.dac_overflow | (ovf_sticky_r & ~rd_ovf_sticky);
			oc_sticky_r  <= s2_r.hp_overcurrent | (oc_sticky_r & ~rd_oc_sticky);
		end
	end

	// interrupt control registers; only enable and pulse-mode bits store
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_pin_one_ctrl_r <= `DSFR_RST_CTRL;
			interrupt_pin_two_ctrl_r <= `DSFR_RST_CTRL;
		end else begin
			if (wr_interrupt_pin_one) interrupt_pin_one_ctrl_r <= req.wdata & 8'h09;
			if (wr_interrupt_pin_two) interrupt_pin_two_ctrl_r <= req.wdata & 8'h09;
		end
	end

	// read mux; reserved and unmapped offsets return zero, flags ignore writes
	always_comb begin
		rdata = 8'h00;
		unique case (req.addr)
			`DSFR_OFF_GAIN_STATUS: rdata[`DSFR_BIT_GAIN_MATCH] = s2_r.gain_match;
			`DSFR_OFF_OVF_STICKY:  rdata[`DSFR_BIT_FLAG] = ovf_sticky_r;
			`DSFR_OFF_OVF_LIVE:    rdata[`DSFR_BIT_FLAG] = s2_r.dac_overflow;
			`DSFR_OFF_OC_STICKY:   rdata[`DSFR_BIT_FLAG] = oc_sticky_r;
			`DSFR_OFF_OC_LIVE:     rdata[`DSFR_BIT_FLAG] = s2_r.hp_overcurrent;
			`DSFR_OFF_INTERRUPT_PIN_ONE_CTRL:   rdata = interrupt_pin_one_ctrl_r;
			`DSFR_OFF_INTERRUPT_PIN_TWO_CTRL:   rdata = interrupt_pin_two_ctrl_r;
			default:               rdata = 8'h00;
		endcase
	end

	dsfr_int_pin #(.PULSE_CYCLES(PULSE_CYCLES)) u_interrupt_pin_one (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.enable     (interrupt_pin_one_ctrl_r[`DSFR_BIT_OC_EN]),
		.train_mode (interrupt_pin_one_ctrl_r[`DSFR_BIT_PULSE_MODE]),
		.oc_rise    (oc_rise),
		.stop_train (stop_train),
		.pin        (interrupt_pin_one)
	);

	dsfr_int_pin #(.PULSE_CYCLES(PULSE_CYCLES)) u_interrupt_pin_two (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.enable     (interrupt_pin_two_ctrl_r[`DSFR_BIT_OC_EN]),
		.train_mode (interrupt_pin_two_ctrl_r[`DSFR_BIT_PULSE_MODE]),
		.oc_rise    (oc_rise),
		.stop_train (stop_train),
		.pin        (interrupt_pin_two)
	);

	property p_sticky_set;
		@(posedge mclk) disable iff (!reset_n)
		s2_r.dac_overflow |=> ovf_sticky_r;
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("overflow not latched");

	property p_sticky_clr;
		@(posedge mclk) disable iff (!reset_n)
		(rd_ovf_sticky && !s2_r.dac_overflow) |=> !ovf_sticky_r;
	endproperty
	a_sticky_clr: assert property (p_sticky_clr) else $error("overflow sticky not cleared");

	property p_oc_race;
		@(posedge mclk) disable iff (!reset_n)
		(rd_oc_sticky && s2_r.hp_overcurrent) |=> oc_sticky_r;
	endproperty
	a_oc_race: assert property (p_oc_race) else $error("over-current lost on read");

	property p_oc_clr;
		@(posedge mclk) disable iff (!reset_n)
		(rd_oc_sticky && !s2_r.hp_overcurrent) |=> !oc_sticky_r;
	endproperty
	a_oc_clr: assert property (p_oc_clr) else $error("over-current sticky not cleared");

	// live reads are held against the raw condition two edges back, so the synchroniser is checked too
	property p_live_ovf;
		@(posedge mclk) disable iff (!reset_n)
		($past(reset_n, 2) && req.addr == `DSFR_OFF_OVF_LIVE) |-> (rdata == {$past(cond_async.dac_overflow, 2), 7'h00});
	endproperty
	a_live_ovf: assert property (p_live_ovf) else $error("live overflow wrong");

	property p_live_oc;
		@(posedge mclk) disable iff (!reset_n)
		($past(reset_n, 2) && req.addr == `DSFR_OFF_OC_LIVE) |-> (rdata == {$past(cond_async.hp_overcurrent, 2), 7'h00});
	endproperty
	a_live_oc: assert property (p_live_oc) else $error("live over-current wrong");

	property p_gain;
		@(posedge mclk) disable iff (!reset_n)
		($past(reset_n, 2) && req.addr == `DSFR_OFF_GAIN_STATUS) |-> (rdata == {3'h0, $past(cond_async.gain_match, 2), 4'h0});
	endproperty
	a_gain: assert property (p_gain) else $error("gain status wrong");

	property p_wr_ignored;
		@(posedge mclk) disable iff (!reset_n)
		(req.wr && !req.rd && !s2_r.dac_overflow) |=> (ovf_sticky_r == $past(ovf_sticky_r));
	endproperty
	a_wr_ignored: assert property (p_wr_ignored) else $error("write changed a flag");

	property p_oc_wr_ignored;
		@(posedge mclk) disable iff (!reset_n)
		(req.wr && !req.rd && !s2_r.hp_overcurrent) |=> (oc_sticky_r == $past(oc_sticky_r));
	endproperty
	a_oc_wr_ignored: assert property (p_oc_wr_ignored) else $error("write changed over-current flag");

	property p_oc_set;
		@(posedge mclk) disable iff (!reset_n)
		s2_r.hp_overcurrent |=> oc_sticky_r;
	endproperty
	a_oc_set: assert property (p_oc_set) else $error("over-current not latched");

	property p_ovf_race;
		@(posedge mclk) disable iff (!reset_n)
		(rd_ovf_sticky && s2_r.dac_overflow) |=> ovf_sticky_r;
	endproperty
	a_ovf_race: assert property (p_ovf_race) else $error("overflow lost on read");

	property p_rsv_zero;
		@(posedge mclk) disable iff (!reset_n)
		(req.addr inside {[`DSFR_OFF_RSV_LO:`DSFR_OFF_RSV_HI], `DSFR_OFF_RSV_2D, `DSFR_OFF_RSV_2F}) |-> (rdata == 8'h00);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved register not zero");

	// pin high-time counters, kept outside the sequencer so the checks see only the pins
	logic [31:0] hi1_r, hi2_r;
	wire  [31:0] pulse_last = 32'(PULSE_CYCLES - 1);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hi1_r <= 32'h0;
			hi2_r <= 32'h0;
		end else begin
			hi1_r <= interrupt_pin_one ? hi1_r + 32'h1 : 32'h0;
			hi2_r <= interrupt_pin_two ? hi2_r + 32'h1 : 32'h0;
		end
	end

	property p_pin1_hold;
		@(posedge mclk) disable iff (!reset_n)
		(interrupt_pin_one && !stop_train && hi1_r < pulse_last) |=> interrupt_pin_one;
	endproperty
	a_pin1_hold: assert property (p_pin1_hold) else $error("pin one pulse too short");

	property p_pin1_end;
		@(posedge mclk) disable iff (!reset_n)
		(interrupt_pin_one && hi1_r == pulse_last) |=> !interrupt_pin_one;
	endproperty
	a_pin1_end: assert property (p_pin1_end) else $error("pin one pulse too long");

	property p_pin2_hold;
		@(posedge mclk) disable iff (!reset_n)
		(interrupt_pin_two && !stop_train && hi2_r < pulse_last) |=> interrupt_pin_two;
	endproperty
	a_pin2_hold: assert property (p_pin2_hold) else $error("pin two pulse too short");

	property p_pin2_end;
		@(posedge mclk) disable iff (!reset_n)
		(interrupt_pin_two && hi2_r == pulse_last) |=> !interrupt_pin_two;
	endproperty
	a_pin2_end: assert property (p_pin2_end) else $error("pin two pulse too long");

	property p_pin1_stop;
		@(posedge mclk) disable iff (!reset_n)
		(interrupt_pin_one && stop_train) |=> !interrupt_pin_one;
	endproperty
	a_pin1_stop: assert property (p_pin1_stop) else $error("pin one ignored sticky read");

	property p_pin2_stop;
		@(posedge mclk) disable iff (!reset_n)
		(interrupt_pin_two && stop_train) |=> !interrupt_pin_two;
	endproperty
	a_pin2_stop: assert property (p_pin2_stop) else $error("pin two ignored sticky read");
endmodule : dsfr_flag_regs

/* sim/dsfr_host_model.sv */
`timescale 1ns/1ns
`include "dsfr_defines.svh"
// control-port host: one-cycle strobes launched at the falling edge
module dsfr_host_model (
	// clock
	input  wire logic           mclk,
	// register access towards the device
	output dsfr_pkg::dsfr_req_t req,
	input  wire logic [7:0]     rdata
);
	// idle until the first task call
	initial req = '0;
	// rdata is taken at the rising edge that takes the strobe, before a read-clear lands
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge mclk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge mclk);
		d = rdata;
		@(negedge mclk);
		req <= '0;
	endtask : rd
	// reserved places only ever get zeros, whatever the caller asks for
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge mclk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a,
			wdata: (a >= `DSFR_OFF_GAIN_STATUS && a <= `DSFR_OFF_RSV_2F) ? 8'h00 : d};
		@(negedge mclk);
		req <= '0;
	endtask : wr
endmodule : dsfr_host_model

/* sim/test_dsfr_flag_regs.sv */
`timescale 1ns/1ns
`include "dsfr_defines.svh"
module test_dsfr_flag_regs;
	localparam int PC = 20;
	logic                 mclk       = 1'b0;
	logic                 reset_n    = 1'b0;
	dsfr_pkg::dsfr_req_t  req;
	dsfr_pkg::dsfr_cond_t cond       = '0;
	logic [7:0]           rdata;
	logic [7:0]           d;
	logic                 p1;
	logic                 p2;
	int                   fails      = 0;
	int                   n_compared = 0;
	int                   cycles     = 0;
	// clock
	always #5 mclk = ~mclk;
	dsfr_flag_regs #(.PULSE_CYCLES(PC)) dsfr_flag_regs_i (.mclk(mclk), .reset_n(reset_n), .req(req),
		.rdata(rdata), .cond_async(cond), .interrupt_pin_one(p1), .interrupt_pin_two(p2));
	dsfr_host_model dsfr_host_model_i (.mclk(mclk), .req(req), .rdata(rdata));
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: pin got %h expected %h", $time, g, e);
		end
	endtask : chk1
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		dsfr_host_model_i.rd(a, d);
		chk8(d, e);
	endtask : rchk
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask : wait_n
	task automatic stop_test;
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic t_reset;
		rchk(`DSFR_OFF_GAIN_STATUS, 8'h00);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h00);
		rchk(`DSFR_OFF_OVF_LIVE, 8'h00);
		rchk(`DSFR_OFF_OC_STICKY, 8'h00);
		rchk(`DSFR_OFF_OC_LIVE, 8'h00);
		rchk(`DSFR_OFF_RSV_LO, 8'h00);
		rchk(`DSFR_OFF_RSV_HI, 8'h00);
		rchk(`DSFR_OFF_RSV_2D, 8'h00);
		rchk(`DSFR_OFF_RSV_2F, 8'h00);
		rchk(`DSFR_OFF_INTERRUPT_PIN_ONE_CTRL, 8'h00);
		chk1(p1 | p2, 1'b0);
	endtask : t_reset
	task automatic t_gain;
		cond.gain_match = 1'b1;
		wait_n(5);
		rchk(`DSFR_OFF_GAIN_STATUS, 8'h10);
		cond.gain_match = 1'b0;
		wait_n(5);
		rchk(`DSFR_OFF_GAIN_STATUS, 8'h00);
	endtask : t_gain
	// the write of zero lands while the sticky bit is set, so an ignored write shows
	task automatic t_ovf;
		cond.dac_overflow = 1'b1;
		wait_n(5);
		rchk(`DSFR_OFF_OVF_LIVE, 8'h80);
		cond.dac_overflow = 1'b0;
		wait_n(5);
		rchk(`DSFR_OFF_OVF_LIVE, 8'h00);
		dsfr_host_model_i.wr(`DSFR_OFF_OVF_STICKY, 8'h00);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h80);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h00);
	endtask : t_ovf
	task automatic t_oc_off;
		cond.hp_overcurrent = 1'b1;
		wait_n(40);
		chk1(p1 | p2, 1'b0);
		cond.hp_overcurrent = 1'b0;
		wait_n(5);
		rchk(`DSFR_OFF_OC_STICKY, 8'h80);
		rchk(`DSFR_OFF_OC_STICKY, 8'h00);
	endtask : t_oc_off
	// events still present across a clearing read must survive it
	task automatic t_race;
		cond.dac_overflow   = 1'b1;
		cond.hp_overcurrent = 1'b1;
		wait_n(5);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h80);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h80);
		rchk(`DSFR_OFF_OC_STICKY, 8'h80);
		rchk(`DSFR_OFF_OC_STICKY, 8'h80);
		cond.dac_overflow   = 1'b0;
		cond.hp_overcurrent = 1'b0;
		wait_n(5);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h80);
		rchk(`DSFR_OFF_OVF_STICKY, 8'h00);
		rchk(`DSFR_OFF_OC_STICKY, 8'h80);
		rchk(`DSFR_OFF_OC_STICKY, 8'h00);
		chk1(p1 | p2, 1'b0);
	endtask : t_race
	// pin one single pulse, pin two a train; checks sit a few cycles into each phase for margin
	task automatic t_oc;
		dsfr_host_model_i.wr(`DSFR_OFF_INTERRUPT_PIN_ONE_CTRL, 8'h08);
		dsfr_host_model_i.wr(`DSFR_OFF_INTERRUPT_PIN_TWO_CTRL, 8'h09);
		rchk(`DSFR_OFF_INTERRUPT_PIN_ONE_CTRL, 8'h08);
		rchk(`DSFR_OFF_INTERRUPT_PIN_TWO_CTRL, 8'h09);
		cond.hp_overcurrent = 1'b1;
		wait_n(6);
		chk1(p1 & p2, 1'b1);
		rchk(`DSFR_OFF_OC_LIVE, 8'h80);
		rchk(`DSFR_OFF_OC_LIVE, 8'h80);
		wait_n(20);
		chk1(p1 | p2, 1'b0);
		wait_n(20);
		chk1(p1, 1'b0);
		chk1(p2, 1'b1);
		cond.hp_overcurrent = 1'b0;
		wait_n(3);
		rchk(`DSFR_OFF_OC_STICKY, 8'h80);
		wait_n(35);
		chk1(p2, 1'b0);
		rchk(`DSFR_OFF_OC_STICKY, 8'h00);
	endtask : t_oc
	// cut a hang short well past the few hundred cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		wait_n(20);
		reset_n = 1'b1;
		t_reset();
		t_gain();
		t_ovf();
		t_oc_off();
		t_race();
		t_oc();
		stop_test();
	end
endmodule : test_dsfr_flag_regs
